// file: bench/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
(
  input wire logic clk_in, // Self-timing clock
  input wire logic ce_n_in, // Chip select
  input wire logic oe_n_in, // Output drive
  input wire logic we_n_in, // Write strobe
  input wire logic [FLASH_AW-1:0] addr_in, // Address pins
  input wire logic [15:0] dq_in, // Data pins
  input wire logic powerdown_reset_n_in, // Reset/power-down
  input wire logic wp_in, // Boot protect
  input wire logic vpp_in, // Supply in range
  input wire logic hv_in, // High voltage on reset pin
  input wire logic fail_in, // Forces operation failure
  output logic [15:0] q_out // Device side of data pins
);
  // ==========================================================
  // Behavioural device
  logic [15:0] mem [logic [FLASH_AW-1:0]];
  logic [5:3] err = '0;
  logic [1:0] pend = '0, p;
  logic stmode = 0, susp = 0;
  logic [7:0] lat = '0, d;
  logic [15:0] val, last = '0, o;
  int cnt = 0;
  wire rd = !ce_n_in && !oe_n_in;
  logic wce = 0;
  logic [FLASH_AW-1:0] wa = '0;
  logic [15:0] wd = '0;
  wire [7:0] opst = {cnt == 0 || susp, susp, err, 3'h0};
  wire boot_lock = wa[18:16] == 3'h7 && !wp_in && !hv_in;
  always @(posedge clk_in) if (cnt > 0 && !susp) cnt <= cnt - 1;
  always @(posedge rd) lat <= opst;
  // Write inputs taken mid-cycle: strobe and chip select rise on one edge
  always @(negedge clk_in) begin wce <= !ce_n_in && !we_n_in; wa <= addr_in; wd <= dq_in; end
  always @* begin
    o = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
    val = stmode ? {8'h00, lat} : o;
    if (rd) last = val;
  end
  // Released bus shows inverse of last value, never a stale copy
  assign q_out = rd ? val : ~last;
  always @(posedge we_n_in or negedge powerdown_reset_n_in) begin
    if (!powerdown_reset_n_in) begin
      err = '0; pend = '0; stmode = 0; susp = 0; cnt = 0;
    end else if (wce) begin
      d = wd[7:0];
      p = pend;
      pend = '0;
      if (p == 2'h1) begin
        if (!vpp_in) err[3] = 1;
        else if (boot_lock || fail_in) err[4] = 1;
        else begin mem[wa] = wd & (mem.exists(wa) ? mem[wa] : 16'hFFFF); cnt = 20; end
      end else if (p == 2'h2 && d == CMD_ERASE_CONFIRM) begin
        if (!vpp_in) err = 3'h5;
        else if (boot_lock || fail_in) err[5] = 1;
        else begin
          foreach (mem[k]) if (k[18:16] == wa[18:16]) mem[k] = 16'hFFFF;
          cnt = 200;
        end
      end else if (susp && d == CMD_ERASE_RESUME) susp = 0;
      else case (d)
        CMD_READ_ARRAY: stmode = 0;
        CMD_READ_STATUS: stmode = 1;
        CMD_CLEAR_STATUS: err = '0;
        CMD_PROG_SETUP, CMD_PROG_SETUP_ALT: begin pend = 2'h1; stmode = 1; end
        CMD_ERASE_SETUP: begin pend = 2'h2; stmode = 1; end
        CMD_ERASE_SUSPEND: if (cnt > 0) begin susp = 1; stmode = 1; end
        default: ;
      endcase
    end
  end
endmodule : flash_dev_model

// file: bench/flash_host_ctrl_bench.sv
`timescale 1ns/1ps
module flash_host_ctrl_bench
  import flash_host_pkg::*;
;
  typedef struct packed {logic [2:0] op; logic [5:0] ctrl; logic fl; logic [19:0] a;
    logic [15:0] d; logic [11:0] st; logic [15:0] rv;} row_t;
  logic ref_clk_in = 0, rst_n_in = 0, avs_read = 0, avs_write = 0, fail = 0;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic avs_waitrequest, ce_n, oe_n, we_n, pwr_rst_n, wp, vpp, hv, bm_n, en = 1;
  logic [15:0] dq_in, dq_out, dq_oe, q;
  logic [FLASH_AW-1:0] fa;
  int error_cnt = 0, checked = 0, cyc = 0;
  row_t rows [12] = '{
    '{1, 6'h05, 0, 20'h00010, 16'hA5C3, 12'h080, 16'hA5C3},
    '{1, 6'h25, 0, 20'h00010, 16'h0F0F, 12'h080, 16'h0503},
    '{1, 6'h01, 0, 20'h00010, 16'h0000, 12'h888, 16'h0503},
    '{2, 6'h01, 0, 20'h00010, 16'h0000, 12'h8A8, 16'h0503},
    '{1, 6'h05, 0, 20'h70000, 16'h1234, 12'h890, 16'hFFFF},
    '{1, 6'h07, 0, 20'h70000, 16'h1234, 12'h080, 16'h1234},
    '{1, 6'h0D, 0, 20'h70001, 16'h1234, 12'h080, 16'h1234},
    '{2, 6'h05, 0, 20'h70001, 16'h0000, 12'h8A0, 16'h1234},
    '{1, 6'h05, 1, 20'h00020, 16'h1234, 12'h890, 16'hFFFF},
    '{2, 6'h05, 1, 20'h00020, 16'h0000, 12'h8A0, 16'hFFFF},
    '{2, 6'h05, 0, 20'h00010, 16'h0000, 12'h080, 16'hFFFF},
    '{1, 6'h15, 0, 20'h00040, 16'h00A5, 12'h080, 16'h00A5}};
  always #25 ref_clk_in = ~ref_clk_in;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & q);
  flash_host_ctrl flash_host_ctrl_inst (.ref_clk_in, .rst_n_in, .clk_en_in(en), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_dq_in(dq_in), .flash_dq_out(dq_out),
    .flash_dq_oe_out(dq_oe), .flash_addr_out(fa), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
    .flash_we_n_out(we_n), .powerdown_reset_n_out(pwr_rst_n), .boot_unlock_out(wp), .supply_enable_out(vpp),
    .high_voltage_enable_out(hv), .byte_mode_n_out(bm_n));
  flash_dev_model flash_dev_model_inst (.clk_in(ref_clk_in), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(fa), .dq_in(dq_in), .powerdown_reset_n_in(pwr_rst_n), .wp_in(wp), .vpp_in(vpp), .hv_in(hv),
    .fail_in(fail), .q_out(q));
  // ==========================================================
  // Bus tasks and verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin error_cnt++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] dd);
    @(posedge ref_clk_in);
    avs_address <= a; avs_writedata <= dd; avs_write <= w; avs_read <= !w;
    do @(posedge ref_clk_in); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0; avs_read <= 0;
  endtask : acc
  task automatic run(input logic [2:0] op);
    acc(1, REG_CMD, 32'(op));
    repeat (400) begin acc(0, REG_STAT, 0); if (rd[STAT_BUSY] === 1'b0) break; end
  endtask : run
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the few thousand cycles needed
  always @(posedge ref_clk_in) begin cyc++; if (cyc == 20000) begin error_cnt++; give_verdict(); end end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1;
    repeat (3) @(posedge ref_clk_in);
    foreach (rows[i]) begin
      fail <= rows[i].fl;
      acc(1, REG_CTRL, 32'(rows[i].ctrl)); acc(1, REG_ADDR, 32'(rows[i].a)); acc(1, REG_DATA, 32'(rows[i].d));
      run(rows[i].op); chk("stat", 32'(rows[i].st), rd);
      chk("byte_n", 32'(!rows[i].ctrl[CTRL_BYTE_MODE]), 32'(bm_n));
      run(3'h6); acc(0, REG_RDATA, 0); chk("rdata", 32'(rows[i].rv), rd);
    end
    fail <= 0;
    acc(1, REG_CTRL, 32'h05); acc(1, REG_CMD, 32'h2);
    repeat (50) begin acc(0, REG_STAT, 0); if (rd[7] === 1'b0) break; end
    run(3'h3); chk("suspend", 32'h2C0, rd);
    acc(1, REG_CMD, 32'h1); acc(0, REG_STAT, 0); chk("susp_refuse", 32'h6C0, rd);
    run(3'h4); chk("resume", 32'h080, rd);
    acc(1, REG_CTRL, 32'h04); run(3'h1); chk("pd_refuse", 32'h480, rd);
    acc(0, 5'h1C, 0); chk("unmapped", 32'h0, rd);
    // Clock enable low: a held read must get no answer
    @(posedge ref_clk_in);
    en <= 0;
    avs_address <= REG_CTRL;
    avs_read <= 1;
    repeat (4) @(posedge ref_clk_in);
    chk("frozen", 32'h1, 32'(avs_waitrequest));
    en <= 1;
    do @(posedge ref_clk_in); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    chk("en_ctrl", 32'h04, rd);
    rst_n_in <= 0;
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1;
    repeat (3) @(posedge ref_clk_in);
    acc(0, REG_CTRL, 0); chk("ctrl_rst", 32'(CTRL_RESET), rd);
    acc(0, REG_STAT, 0); chk("stat_rst", 32'h080, rd);
    give_verdict();
  end
endmodule : flash_host_ctrl_bench

// file: rtl/flash_bus_cycle.sv
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic rst_n_in, // Synchronised reset, active low
  input wire logic clk_en_in, // Freezes state while low
  input wire logic req_in, // One-cycle request strobe
  input wire bus_req_t breq_in, // Request contents
  input wire logic [15:0] dq_in, // Data pins as seen
  output logic done_out, // One-cycle completion pulse
  output logic [15:0] rdata_out, // Captured read data
  output pins_t pins_out // Flash strobes, address, data drive
);

  cyc_st_t st_ff;
  cyc_st_t nxt_st;

  // ==========================================================
  // One flash access: chip-select, strobe, release
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.ph)
      E_IDLE: begin
        if (req_in) begin
          nxt_st.ph = E_SETUP;
          nxt_st.wr = breq_in.wr;
          nxt_st.byte_mode = breq_in.byte_mode;
          nxt_st.cnt = STROBE_CYC - 4'h1;
          nxt_st.pins.ce_n = 1'b0;
          // In byte mode the top data pin carries the lowest address bit
          nxt_st.pins.addr = breq_in.byte_mode ? breq_in.addr[19:1] : breq_in.addr[FLASH_AW-1:0];
          nxt_st.pins.dq_out = {breq_in.byte_mode ? breq_in.addr[0] : breq_in.data[15], breq_in.data[14:0]};
          if (breq_in.wr) begin
            nxt_st.pins.dq_oe = breq_in.byte_mode ? 16'h80FF : 16'hFFFF;
          end else begin
            nxt_st.pins.dq_oe = breq_in.byte_mode ? 16'h8000 : 16'h0000;
          end
        end
      end
      E_SETUP: begin
        nxt_st.ph = E_STROBE;
        nxt_st.pins.we_n = !st_ff.wr;
        nxt_st.pins.oe_n = st_ff.wr;
      end
      E_STROBE: begin
        if (st_ff.cnt != 4'h0) begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end else begin
          if (!st_ff.wr) begin
            nxt_st.rdata = st_ff.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
          end
          // Full release so the next poll is a fresh access
          nxt_st.pins.we_n = 1'b1;
          nxt_st.pins.oe_n = 1'b1;
          nxt_st.pins.ce_n = 1'b1;
          nxt_st.pins.dq_oe = st_ff.byte_mode ? 16'h8000 : 16'h0000;
          nxt_st.ph = E_RECOVER;
          nxt_st.cnt = RECOVER_CYC - 4'h1;
        end
      end
      E_RECOVER: begin
        if (st_ff.cnt != 4'h0) begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end else begin
          nxt_st.ph = E_IDLE;
          nxt_st.done = 1'b1;
        end
      end
      default: nxt_st.ph = E_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '{ph: E_IDLE, cnt: 4'h0, wr: 1'b0, byte_mode: 1'b0, done: 1'b0, rdata: 16'h0000,
                 pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: 16'h0000, dq_oe: 16'h0000}};
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  assign done_out = st_ff.done;
  assign rdata_out = st_ff.rdata;
  assign pins_out = st_ff.pins;

  // ==========================================================
  // Checks
  property p_poll_release;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_ff.ph == E_STROBE && st_ff.cnt == 4'h0 && clk_en_in) |=>
      (st_ff.pins.oe_n && st_ff.pins.ce_n && st_ff.pins.we_n);
  endproperty
  a_poll_release: assert property (p_poll_release) else $error("strobes not released after access");

  property p_ce_before_we;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(st_ff.pins.we_n) |-> (!st_ff.pins.ce_n && !$past(st_ff.pins.ce_n));
  endproperty
  a_ce_before_we: assert property (p_ce_before_we) else $error("write strobe without prior chip select");

endmodule : flash_bus_cycle

// file: rtl/flash_host_ctrl.sv
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic rst_n_in, // Asynchronous reset, active low
  input wire logic clk_en_in, // Freezes all state but the reset synchroniser while low
  input wire logic [4:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic [15:0] flash_dq_in, // Flash data pins in
  output logic [15:0] flash_dq_out, // Flash data pins out
  output logic [15:0] flash_dq_oe_out, // Per-bit drive enable, high drives
  output logic [FLASH_AW-1:0] flash_addr_out, // Flash address pins
  output logic flash_ce_n_out, // Chip select, active low
  output logic flash_oe_n_out, // Output drive, active low
  output logic flash_we_n_out, // Write strobe, active low
  output logic powerdown_reset_n_out, // Reset/power-down pin, active low
  output logic boot_unlock_out, // Boot-protect pin level
  output logic supply_enable_out, // Switches program supply on
  output logic high_voltage_enable_out, // Raises reset pin to high voltage
  output logic byte_mode_n_out // Low selects 8-bit bus
);

  logic [1:0] rst_sync_ff;
  host_st_t st_ff;
  host_st_t nxt_st;
  logic bus_done;
  logic [15:0] bus_rdata;
  pins_t pins;
  logic [31:0] wdat;

  // ==========================================================
  // Reset release
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  function automatic bus_req_t mk_req(input logic wr, input logic [19:0] addr, input logic [7:0] code,
                                      input logic byte_mode);
    bus_req_t r;
    r.wr = wr;
    r.addr = addr;
    r.data = {8'h00, code};
    r.byte_mode = byte_mode;
    return r;
  endfunction : mk_req

  // ==========================================================
  // Register slave and sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_st.req = 1'b0;
    wdat = avs_writedata;
    if ((avs_read || avs_write) && st_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
      case (avs_address)
        REG_CMD: nxt_st.rddata = {29'h0, st_ff.op};
        REG_ADDR: nxt_st.rddata = {12'h000, st_ff.addr};
        REG_DATA: nxt_st.rddata = {16'h0000, st_ff.wdata};
        REG_CTRL: nxt_st.rddata = {26'h0, st_ff.ctrl};
        REG_STAT: nxt_st.rddata = {20'h0, |(st_ff.status & 8'h38), st_ff.refused, st_ff.susp, st_ff.busy,
                                   st_ff.status};
        REG_RDATA: nxt_st.rddata = {16'h0000, st_ff.rdata};
        default: nxt_st.rddata = 32'h0000_0000;
      endcase
    end else begin
      nxt_st.waitreq = 1'b1;
    end
    if (avs_write && !st_ff.waitreq) begin
      case (avs_address)
        REG_ADDR: nxt_st.addr = wdat[19:0];
        REG_DATA: nxt_st.wdata = wdat[15:0];
        REG_CTRL: if (!st_ff.busy) nxt_st.ctrl = wdat[5:0];
        REG_CMD: begin
          nxt_st.refused = 1'b1;
          if (st_ff.state == H_IDLE && st_ff.ctrl[CTRL_PD_RELEASE]) begin
            nxt_st.refused = 1'b0;
            nxt_st.busy = 1'b1;
            nxt_st.op = op_t'(wdat[2:0]);
            case (op_t'(wdat[2:0]))
              OP_PROGRAM, OP_ERASE, OP_CLEAR: nxt_st.state = H_CLEAR;
              OP_READ_ARRAY: nxt_st.state = H_ARR_CMD;
              OP_READ_STATUS: nxt_st.state = H_STAT_CMD;
              default: begin
                nxt_st.busy = 1'b0;
                nxt_st.refused = 1'b1;
              end
            endcase
          end else if (st_ff.state == H_SUSPENDED) begin
            // Only these three may follow a suspend
            nxt_st.refused = 1'b0;
            nxt_st.busy = 1'b1;
            nxt_st.op = op_t'(wdat[2:0]);
            case (op_t'(wdat[2:0]))
              OP_RESUME: nxt_st.state = H_RESUME;
              OP_READ_ARRAY: nxt_st.state = H_ARR_CMD;
              OP_READ_STATUS: nxt_st.state = H_STAT_CMD;
              default: begin
                nxt_st.busy = 1'b0;
                nxt_st.refused = 1'b1;
                nxt_st.op = st_ff.op;
              end
            endcase
          end else if (st_ff.state == H_POLL && st_ff.op == OP_ERASE && wdat[2:0] == OP_SUSPEND) begin
            nxt_st.refused = 1'b0;
            nxt_st.susp_req = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Each state other than idle and suspended issues one access, then waits for its completion
    if (!st_ff.pend && st_ff.state != H_IDLE && st_ff.state != H_SUSPENDED) begin
      nxt_st.pend = 1'b1;
      nxt_st.req = 1'b1;
      case (st_ff.state)
        H_CLEAR: nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_CLEAR_STATUS, st_ff.ctrl[CTRL_BYTE_MODE]);
        H_SETUP: nxt_st.breq = mk_req(1'b1, st_ff.addr, (st_ff.op == OP_ERASE) ? CMD_ERASE_SETUP :
                                      (st_ff.ctrl[CTRL_ALT_PROG] ? CMD_PROG_SETUP_ALT : CMD_PROG_SETUP),
                                      st_ff.ctrl[CTRL_BYTE_MODE]);
        H_SECOND: begin
          // Confirm goes to the same block address as the setup
          nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_ERASE_CONFIRM, st_ff.ctrl[CTRL_BYTE_MODE]);
          if (st_ff.op == OP_PROGRAM) begin
            nxt_st.breq.data = st_ff.wdata;
          end
        end
        H_SUSP_CMD: nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_ERASE_SUSPEND, st_ff.ctrl[CTRL_BYTE_MODE]);
        H_RESUME: nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_ERASE_RESUME, st_ff.ctrl[CTRL_BYTE_MODE]);
        H_ARR_CMD: nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_READ_ARRAY, st_ff.ctrl[CTRL_BYTE_MODE]);
        H_STAT_CMD: nxt_st.breq = mk_req(1'b1, st_ff.addr, CMD_READ_STATUS, st_ff.ctrl[CTRL_BYTE_MODE]);
        default: nxt_st.breq = mk_req(1'b0, st_ff.addr, 8'h00, st_ff.ctrl[CTRL_BYTE_MODE]);
      endcase
    end else if (st_ff.pend && bus_done) begin
      nxt_st.pend = 1'b0;
      case (st_ff.state)
        H_CLEAR: begin
          nxt_st.status = st_ff.status & ~8'h38;
          if (st_ff.op == OP_CLEAR) begin
            nxt_st.state = H_IDLE;
            nxt_st.busy = 1'b0;
          end else begin
            nxt_st.state = H_SETUP;
          end
        end
        H_SETUP: nxt_st.state = H_SECOND;
        H_SECOND, H_RESUME: begin
          nxt_st.state = H_POLL;
          nxt_st.susp = 1'b0;
        end
        H_POLL: begin
          // Reserved bits are masked; only the low byte carries status
          nxt_st.status = bus_rdata[7:0] & OPST_VALID_MASK;
          if (bus_rdata[OPST_READY]) begin
            nxt_st.state = H_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.susp_req = 1'b0;
          end else if (st_ff.susp_req) begin
            nxt_st.state = H_SUSP_CMD;
          end
        end
        H_SUSP_CMD: nxt_st.state = H_SUSP_POLL;
        H_SUSP_POLL: begin
          nxt_st.status = bus_rdata[7:0] & OPST_VALID_MASK;
          if (bus_rdata[OPST_READY]) begin
            nxt_st.susp_req = 1'b0;
            nxt_st.busy = 1'b0;
            nxt_st.susp = bus_rdata[OPST_SUSPENDED];
            nxt_st.state = bus_rdata[OPST_SUSPENDED] ? H_SUSPENDED : H_IDLE;
          end
        end
        H_ARR_CMD: nxt_st.state = H_ARR_READ;
        H_STAT_CMD: nxt_st.state = H_STAT_READ;
        H_ARR_READ, H_STAT_READ: begin
          if (st_ff.state == H_ARR_READ) begin
            nxt_st.rdata = bus_rdata;
          end else begin
            nxt_st.status = bus_rdata[7:0] & OPST_VALID_MASK;
          end
          nxt_st.busy = 1'b0;
          nxt_st.state = st_ff.susp ? H_SUSPENDED : H_IDLE;
        end
        default: nxt_st.state = H_IDLE;
      endcase
    end
    if (st_ff.state == H_ARR_READ || st_ff.state == H_STAT_READ || st_ff.state == H_POLL ||
        st_ff.state == H_SUSP_POLL) begin
      nxt_st.breq.wr = st_ff.pend ? st_ff.breq.wr : 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_ff[1]) begin
    if (!rst_sync_ff[1]) begin
      st_ff <= '{state: H_IDLE, op: OP_NONE, addr: 20'h00000, wdata: 16'h0000, ctrl: CTRL_RESET,
                 status: OPST_RESET, rdata: 16'h0000, busy: 1'b0, susp: 1'b0, refused: 1'b0, susp_req: 1'b0,
                 pend: 1'b0, req: 1'b0, breq: '0, waitreq: 1'b1, rddata: 32'h0000_0000};
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Pin engine
  flash_bus_cycle u_cycle (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_sync_ff[1]),
    .clk_en_in(clk_en_in),
    .req_in(st_ff.req),
    .breq_in(st_ff.breq),
    .dq_in(flash_dq_in),
    .done_out(bus_done),
    .rdata_out(bus_rdata),
    .pins_out(pins)
  );

  assign avs_readdata = st_ff.rddata;
  assign avs_waitrequest = st_ff.waitreq;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe_out = pins.dq_oe;
  assign flash_addr_out = pins.addr;
  assign flash_ce_n_out = pins.ce_n;
  assign flash_oe_n_out = pins.oe_n;
  assign flash_we_n_out = pins.we_n;
  // Protection straps only change while not busy: idle, or with an erase suspended
  assign powerdown_reset_n_out = st_ff.ctrl[CTRL_PD_RELEASE];
  assign boot_unlock_out = st_ff.ctrl[CTRL_BOOT_UNLOCK];
  assign supply_enable_out = st_ff.ctrl[CTRL_SUPPLY_ON];
  assign high_voltage_enable_out = st_ff.ctrl[CTRL_HV_ON];
  assign byte_mode_n_out = !st_ff.ctrl[CTRL_BYTE_MODE];

  // ==========================================================
  // Checks
  property p_clear_first;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.state == H_SETUP && $past(st_ff.state) != H_SETUP) |-> $past(st_ff.state) == H_CLEAR;
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("setup not preceded by clear status");

  property p_prog_second;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && st_ff.state == H_SECOND && st_ff.op == OP_PROGRAM) |->
      (st_ff.breq.wr && st_ff.breq.data == st_ff.wdata && st_ff.breq.addr == st_ff.addr);
  endproperty
  a_prog_second: assert property (p_prog_second) else $error("program data write wrong");

  property p_prog_code;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && st_ff.state == H_SETUP && st_ff.op == OP_PROGRAM) |->
      (st_ff.breq.data[7:0] == CMD_PROG_SETUP || st_ff.breq.data[7:0] == CMD_PROG_SETUP_ALT);
  endproperty
  a_prog_code: assert property (p_prog_code) else $error("bad program setup code");

  property p_erase_codes;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && st_ff.state == H_SETUP && st_ff.op == OP_ERASE) |->
      st_ff.breq.data[7:0] == CMD_ERASE_SETUP ##1
      (st_ff.state == H_SETUP || st_ff.state == H_SECOND)[*1] ##0 (st_ff.addr == $past(st_ff.addr));
  endproperty
  a_erase_codes: assert property (p_erase_codes) else $error("erase setup code or block address wrong");

  property p_confirm;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && st_ff.state == H_SECOND && st_ff.op == OP_ERASE) |->
      (st_ff.breq.data[7:0] == CMD_ERASE_CONFIRM && st_ff.breq.addr == st_ff.addr);
  endproperty
  a_confirm: assert property (p_confirm) else $error("erase confirm wrong");

  property p_busy_reads_only;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && (st_ff.state == H_POLL || st_ff.state == H_SUSP_POLL)) |-> !st_ff.breq.wr;
  endproperty
  a_busy_reads_only: assert property (p_busy_reads_only) else $error("write issued while busy");

  property p_susp_cmds;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.req && st_ff.susp && st_ff.breq.wr) |->
      (st_ff.breq.data[7:0] == CMD_READ_ARRAY || st_ff.breq.data[7:0] == CMD_ERASE_RESUME ||
       st_ff.breq.data[7:0] == CMD_READ_STATUS);
  endproperty
  a_susp_cmds: assert property (p_susp_cmds) else $error("illegal command while suspended");

  property p_array_after_cmd;
    @(posedge ref_clk_in) disable iff (!rst_sync_ff[1])
    (st_ff.state == H_ARR_READ && $past(st_ff.state) != H_ARR_READ) |-> $past(st_ff.state) == H_ARR_CMD;
  endproperty
  a_array_after_cmd: assert property (p_array_after_cmd) else $error("array read without read-array");

endmodule : flash_host_ctrl

// file: rtl/flash_host_pkg.sv
package flash_host_pkg;

  // ==========================================================
  // Flash geometry and command codes
  localparam int FLASH_AW = 19;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;

  // ==========================================================
  // Device operation_status fields
  localparam int OPST_READY = 7;
  localparam int OPST_SUSPENDED = 6;
  localparam int OPST_ERASE_FAIL = 5;
  localparam int OPST_PROG_FAIL = 4;
  localparam int OPST_SUPPLY_LOW = 3;
  localparam logic [7:0] OPST_VALID_MASK = 8'hF8;
  localparam logic [7:0] OPST_RESET = 8'h80;

  // ==========================================================
  // Software register map (byte offsets)
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_CTRL = 5'h0C;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam logic [4:0] REG_RDATA = 5'h14;
  localparam int CTRL_PD_RELEASE = 0;
  localparam int CTRL_BOOT_UNLOCK = 1;
  localparam int CTRL_SUPPLY_ON = 2;
  localparam int CTRL_HV_ON = 3;
  localparam int CTRL_BYTE_MODE = 4;
  localparam int CTRL_ALT_PROG = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  localparam int STAT_BUSY = 8;
  localparam int STAT_SUSP = 9;
  localparam int STAT_REFUSED = 10;
  localparam int STAT_ERROR = 11;

  // ==========================================================
  // Bus cycle timing
  localparam int CLK_MHZ = 20;
  localparam int STROBE_NS = 100;
  localparam int RECOVER_NS = 50;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2, OP_SUSPEND = 3'h3,
    OP_RESUME = 3'h4, OP_CLEAR = 3'h5, OP_READ_ARRAY = 3'h6, OP_READ_STATUS = 3'h7
  } op_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_CLEAR = 4'h1, H_SETUP = 4'h2, H_SECOND = 4'h3, H_POLL = 4'h4,
    H_SUSP_CMD = 4'h5, H_SUSP_POLL = 4'h6, H_SUSPENDED = 4'h7, H_RESUME = 4'h8,
    H_ARR_CMD = 4'h9, H_ARR_READ = 4'hA, H_STAT_CMD = 4'hB, H_STAT_READ = 4'hC
  } h_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0, E_SETUP = 2'h1, E_STROBE = 2'h2, E_RECOVER = 2'h3
  } e_state_t;

  typedef struct packed {
    logic wr;
    logic byte_mode;
    logic [19:0] addr;
    logic [15:0] data;
  } bus_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [FLASH_AW-1:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } pins_t;

  typedef struct packed {
    e_state_t ph;
    logic [3:0] cnt;
    logic wr;
    logic byte_mode;
    logic done;
    logic [15:0] rdata;
    pins_t pins;
  } cyc_st_t;

  typedef struct packed {
    h_state_t state;
    op_t op;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [5:0] ctrl;
    logic [7:0] status;
    logic [15:0] rdata;
    logic busy;
    logic susp;
    logic refused;
    logic susp_req;
    logic pend;
    logic req;
    bus_req_t breq;
    logic waitreq;
    logic [31:0] rddata;
  } host_st_t;

endpackage : flash_host_pkg
